// *** design/bum_serial_ctrl.sv ***
// Band unit serial control: PLL, top band, volume and squelch words plus band identification
`timescale 1ns/1ns
module bum_serial_ctrl
  import bum_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      cmd_valid,
  input  wire bum_cmd_t  cmd,
  output logic           cmd_ready,
  input  wire logic      mem_clear,
  input  wire logic      top_ref_sel,
  input  wire bum_link_t link_in,
  output bum_link_t      link_out,
  output bum_link_t      link_oe,
  output logic           shift_register_enable,
  output bum_top_t       top_link,
  input  wire logic      speaker_jack_detect,
  input  wire logic      squelch_busy_n,
  output bum_band_t      band_id,
  output logic           ident_done,
  output logic           speaker_present,
  output logic           channel_busy
);

  typedef enum logic [2:0] {ST_ID_FLOAT, ST_IDLE, ST_FETCH, ST_BIT_SET, ST_BIT_HIGH, ST_BIT_LOW, ST_LATCH}
    bum_state_t;

  bum_state_t   state, next_state;
  logic [7:0]   timer, next_timer;
  logic [31:0]  shreg, next_shreg;
  logic [5:0]   bits_left, next_bits_left;
  bum_target_t  target, next_target;
  logic [2:0]   fetch_cnt, next_fetch_cnt;
  logic [2:0]   fetch_base, next_fetch_base;
  logic [19:0]  gather, next_gather;
  logic [7:0]   vol_cmd, next_vol_cmd;
  logic         top_ref_pending, next_top_ref_pending;
  logic         top_ref_sel_q, next_top_ref_sel_q;
  logic         next_cmd_ready;
  bum_link_t    next_link_out, next_link_oe;
  logic         next_shift_register_enable;
  bum_top_t     next_top_link;
  bum_band_t    next_band_id;
  logic         next_ident_done;
  logic         next_speaker_present, next_channel_busy;
  logic         accept;
  logic         tick;
  logic         mem_we, mem_re;
  logic [2:0]   mem_addr;
  logic [4:0]   mem_rdata;
  logic [10:0]  band_ratio;
  logic [10:0]  top_ratio;
  logic [16:0]  ref_word;
  logic         bit_out, clk_out, latch_out;

  // ==========================================================================
  // Level store access
  assign accept   = cmd_valid && cmd_ready && (state == ST_IDLE);
  assign mem_we   = accept && (cmd.kind == BUM_LEVEL_WR);
  assign mem_re   = (state == ST_FETCH) && (fetch_cnt != FETCH_END);
  assign mem_addr = mem_we ? cmd.addr : (fetch_base + fetch_cnt);
  assign tick     = (timer == 8'h00);

  bum_level_mem u_mem (
    .clk   (clk),
    .we    (mem_we),
    .re    (mem_re),
    .addr  (mem_addr),
    .wdata (cmd.value[4:0]),
    .rdata (mem_rdata)
  );

  // Reference ratios from the selected reference frequency
  assign band_ratio = cmd.value[0] ? REF_DIV_6K : REF_DIV_5K;
  assign top_ratio  = top_ref_sel_q ? REF_DIV_12K : REF_DIV_10K;
  assign ref_word   = REF_WORD_BASE + {3'h0, band_ratio, 3'h0};

  // ==========================================================================
  // Sequencer: next values for every register except link_out, top_link and shift_register_enable
  always_comb begin
    next_state           = state;
    next_timer           = timer;
    next_shreg           = shreg;
    next_bits_left       = bits_left;
    next_target          = target;
    next_fetch_cnt       = fetch_cnt;
    next_fetch_base      = fetch_base;
    next_gather          = gather;
    next_vol_cmd         = vol_cmd;
    next_band_id         = band_id;
    next_ident_done      = ident_done;
    next_link_oe         = link_oe;
    next_top_ref_sel_q   = top_ref_sel;
    next_top_ref_pending = top_ref_pending;
    next_speaker_present = speaker_jack_detect;
    next_channel_busy    = !squelch_busy_n;

    // Timer runs in every active state and reloads on each tick
    if (state != ST_IDLE) begin
      next_timer = tick ? HALF_RELOAD : timer - 8'h01;
    end

    case (state)
      ST_ID_FLOAT: begin
        next_link_oe = '0;
        if (tick) begin
          next_band_id    = bum_decode(link_in);
          next_ident_done = 1'b1;
          next_link_oe    = '1;
          next_state      = ST_IDLE;
        end
      end
      ST_IDLE: begin
        next_timer = HALF_RELOAD;
        if (top_ref_pending) begin
          // Top band ref word goes before any queued command
          next_top_ref_pending = 1'b0;
          next_target    = TGT_TOP;
          next_shreg     = bum_align({21'h0, top_ratio}, LEN_TOP);
          next_bits_left = LEN_TOP;
          next_state     = ST_BIT_SET;
        end else if (accept) begin
          next_bits_left = LEN_PLL;
          next_target    = TGT_PLL;
          next_state     = ST_BIT_SET;
          case (cmd.kind)
            BUM_PLL_N: begin
              next_shreg = bum_align({11'h0, cmd.value, 1'b0, cmd.addr}, LEN_PLL);
            end
            BUM_PLL_REF: begin
              next_shreg = bum_align({11'h0, ref_word, 4'h0}, LEN_PLL);
            end
            BUM_TOP_N: begin
              next_target    = TGT_TOP;
              next_bits_left = LEN_TOP;
              next_shreg     = bum_align({16'h0, cmd.value[15:0]}, LEN_TOP);
            end
            BUM_VOLUME: begin
              next_vol_cmd    = cmd.value[7:0];
              next_fetch_base = VOL_BASE;
              next_fetch_cnt  = 3'h0;
              next_gather     = '0;
              next_state      = ST_FETCH;
            end
            BUM_SQUELCH: begin
              next_fetch_base = SQL_BASE;
              next_fetch_cnt  = 3'h0;
              next_gather     = '0;
              next_state      = ST_FETCH;
            end
            default: begin
              next_state = ST_IDLE;  // Level writes land in the store directly
            end
          endcase
        end
      end
      ST_FETCH: begin
        // Four 5-bit levels, one read per cycle, band 0 ends up most significant
        next_fetch_cnt = fetch_cnt + 3'h1;
        if (fetch_cnt != 3'h0) begin
          next_gather = {gather[14:0], mem_rdata};
        end
        if (fetch_cnt == FETCH_END) begin
          next_target = TGT_SREG;
          next_state  = ST_BIT_SET;
          next_timer  = HALF_RELOAD;
          if (fetch_base == VOL_BASE) begin
            next_bits_left = LEN_VOL;
            next_shreg     = bum_align({4'h0, vol_cmd, gather[14:0], mem_rdata}, LEN_VOL);
          end else begin
            next_bits_left = LEN_SQL;
            next_shreg     = bum_align({12'h0, gather[14:0], mem_rdata}, LEN_SQL);
          end
        end
      end
      ST_BIT_SET: begin
        if (tick) begin
          next_state = ST_BIT_HIGH;
        end
      end
      ST_BIT_HIGH: begin
        // Data held across the falling edge that the receiver samples on
        if (tick) begin
          next_state = ST_BIT_LOW;
        end
      end
      ST_BIT_LOW: begin
        if (tick) begin
          next_shreg     = {shreg[30:0], 1'b0};
          next_bits_left = bits_left - 6'h01;
          next_state     = (bits_left == 6'h01) ? ST_LATCH : ST_BIT_SET;
        end
      end
      ST_LATCH: begin
        if (tick) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // A reference change in the same cycle as a send keeps the request alive
    if (top_ref_sel != top_ref_sel_q) begin
      next_top_ref_pending = 1'b1;
    end

    // Memory clear restarts identification, dropping any word in flight
    if (mem_clear) begin
      next_state      = ST_ID_FLOAT;
      next_timer      = SETTLE_RELOAD;
      next_ident_done = 1'b0;
      next_link_oe    = '0;
    end

    next_cmd_ready = (next_state == ST_IDLE) && !next_top_ref_pending;
  end

  // ==========================================================================
  // Pin values follow the next state so every pin leaves a flip-flop
  always_comb begin
    bit_out   = 1'b0;
    clk_out   = 1'b0;
    latch_out = 1'b0;
    case (next_state)
      ST_BIT_SET, ST_BIT_LOW: begin
        bit_out = next_shreg[31];
      end
      ST_BIT_HIGH: begin
        bit_out = next_shreg[31];
        clk_out = 1'b1;
      end
      ST_LATCH: begin
        latch_out = 1'b1;
      end
      default: begin
        bit_out = 1'b0;
      end
    endcase
    // Clock and data are shared by PLL and shift registers; only enables differ
    next_link_out.serial_shift_clock   = (next_target != TGT_TOP) && clk_out;
    next_link_out.serial_shift_data    = (next_target != TGT_TOP) && bit_out;
    next_link_out.pll_latch_enable     = (next_target == TGT_PLL) && latch_out;
    next_shift_register_enable         = (next_target == TGT_SREG) && latch_out;
    next_top_link.top_shift_clock       = (next_target == TGT_TOP) && clk_out;
    next_top_link.top_shift_data        = (next_target == TGT_TOP) && bit_out;
    next_top_link.top_band_latch_enable = (next_target == TGT_TOP) && latch_out;
  end

  // ==========================================================================
  // Registers; identification starts straight out of reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state                 <= ST_ID_FLOAT;
      timer                 <= SETTLE_RELOAD;
      shreg                 <= '0;
      bits_left             <= '0;
      target                <= TGT_PLL;
      fetch_cnt             <= '0;
      fetch_base            <= VOL_BASE;
      gather                <= '0;
      vol_cmd               <= '0;
      top_ref_pending       <= RST_TOP_REF_PENDING;
      top_ref_sel_q         <= 1'b0;
      cmd_ready             <= 1'b0;
      link_out              <= '0;
      link_oe               <= '0;
      shift_register_enable <= 1'b0;
      top_link              <= '0;
      band_id               <= BAND_NONE;
      ident_done            <= 1'b0;
      speaker_present       <= 1'b0;
      channel_busy          <= 1'b0;
    end else begin
      state                 <= next_state;
      timer                 <= next_timer;
      shreg                 <= next_shreg;
      bits_left             <= next_bits_left;
      target                <= next_target;
      fetch_cnt             <= next_fetch_cnt;
      fetch_base            <= next_fetch_base;
      gather                <= next_gather;
      vol_cmd               <= next_vol_cmd;
      top_ref_pending       <= next_top_ref_pending;
      top_ref_sel_q         <= next_top_ref_sel_q;
      cmd_ready             <= next_cmd_ready;
      link_out              <= next_link_out;
      link_oe               <= next_link_oe;
      shift_register_enable <= next_shift_register_enable;
      top_link              <= next_top_link;
      band_id               <= next_band_id;
      ident_done            <= next_ident_done;
      speaker_present       <= next_speaker_present;
      channel_busy          <= next_channel_busy;
    end
  end

endmodule

// *** design/bum_pkg.sv ***
// Constants, types and helper functions for the band unit serial control block
package bum_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SHIFT_HALF_NS  = 500;    // Least half period of the shift clock
  localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ID_SETTLE_NS   = 10000;  // Least time the lines float before sampling
  localparam int ID_SETTLE_CYC  = (ID_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HALF_RELOAD   = 8'(SHIFT_HALF_CYC - 1);
  localparam logic [7:0] SETTLE_RELOAD = 8'(ID_SETTLE_CYC - 1);

  // ==========================================================================
  // Reference divider, frequencies kept in 10 Hz units
  // Band PLLs count fref in 100 Hz steps, so 5 kHz gives 320 and 6.25 kHz gives 256
  localparam int REF_NUM_KHZ   = 16000;
  localparam int FREF_5K_X100  = 500;
  localparam int FREF_6K_X100  = 625;
  localparam int FREF_10K_X100 = 1000;
  localparam int FREF_12K_X100 = 1250;
  localparam logic [10:0] REF_DIV_5K   = 11'(REF_NUM_KHZ * 10 / FREF_5K_X100);
  localparam logic [10:0] REF_DIV_6K   = 11'(REF_NUM_KHZ * 10 / FREF_6K_X100);
  localparam logic [10:0] REF_DIV_10K  = 11'(REF_NUM_KHZ * 100 / FREF_10K_X100);
  localparam logic [10:0] REF_DIV_12K  = 11'(REF_NUM_KHZ * 100 / FREF_12K_X100);
  localparam logic [16:0] REF_WORD_BASE = 17'h03200;  // Latch-select offset of the ref word

  // ==========================================================================
  // Word lengths and level store layout
  localparam logic [5:0] LEN_PLL = 6'h15;  // 17 data bits plus 4 control bits
  localparam logic [5:0] LEN_TOP = 6'h10;
  localparam logic [5:0] LEN_VOL = 6'h1c;  // 20 level bits plus 8 command bits
  localparam logic [5:0] LEN_SQL = 6'h14;
  localparam int ADDR_W   = 3;
  localparam int LEVEL_W  = 5;
  localparam int MEM_DEPTH = 8;
  localparam logic [2:0] VOL_BASE  = 3'h0;
  localparam logic [2:0] SQL_BASE  = 3'h4;
  localparam logic [2:0] FETCH_END = 3'h4;

  // ==========================================================================
  // Reset values
  localparam logic RST_TOP_REF_PENDING = 1'b1;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    BUM_PLL_N, BUM_PLL_REF, BUM_TOP_N, BUM_VOLUME, BUM_SQUELCH, BUM_LEVEL_WR
  } bum_kind_t;

  typedef enum logic [1:0] {TGT_PLL, TGT_SREG, TGT_TOP} bum_target_t;

  typedef enum logic [2:0] {
    BAND_NONE, BAND_28, BAND_50, BAND_144, BAND_430, BAND_1200, BAND_UNKNOWN
  } bum_band_t;

  typedef struct packed {
    bum_kind_t   kind;
    logic [2:0]  addr;   // Level slot, or PLL control bits
    logic [16:0] value;  // Ratio, level, ref select or volume command bits
  } bum_cmd_t;

  typedef struct packed {
    logic pll_latch_enable;
    logic serial_shift_clock;
    logic serial_shift_data;
  } bum_link_t;

  typedef struct packed {
    logic top_band_latch_enable;
    logic top_shift_clock;
    logic top_shift_data;
  } bum_top_t;

  // ==========================================================================
  // Functions
  function automatic logic [31:0] bum_align(input logic [31:0] w, input logic [5:0] len);
    bum_align = w << (6'h20 - len);
  endfunction

  function automatic bum_band_t bum_decode(input bum_link_t l);
    logic [2:0] lv;
    lv = {l.serial_shift_data, l.serial_shift_clock, l.pll_latch_enable};
    casez (lv)
      3'b000:  bum_decode = BAND_NONE;
      3'b100:  bum_decode = BAND_28;
      3'b11?:  bum_decode = BAND_50;
      3'b011:  bum_decode = BAND_144;
      3'b101:  bum_decode = BAND_430;
      3'b001:  bum_decode = BAND_1200;
      default: bum_decode = BAND_UNKNOWN;
    endcase
  endfunction

endpackage

// *** design/bum_level_mem.sv ***
// Small level store for the per-band volume and squelch settings
`timescale 1ns/1ns
module bum_level_mem
  import bum_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               we,
  input  wire logic               re,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [LEVEL_W-1:0] wdata,
  output logic      [LEVEL_W-1:0] rdata
);

  logic [LEVEL_W-1:0] mem [MEM_DEPTH];

  // ==========================================================================
  // Storage; read data is registered, so it arrives one cycle after re
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule

// *** tb/bum_serial_ctrl_props.sv ***
// Concurrent checks on the ports of the band unit serial control block
`timescale 1ns/1ns
module bum_serial_ctrl_props
  import bum_pkg::*;
(
  input wire logic      clk,
  input wire logic      sys_rst,
  input wire logic      cmd_valid,
  input wire bum_cmd_t  cmd,
  input wire logic      cmd_ready,
  input wire logic      mem_clear,
  input wire logic      top_ref_sel,
  input wire bum_link_t link_in,
  input wire bum_link_t link_out,
  input wire bum_link_t link_oe,
  input wire logic      shift_register_enable,
  input wire bum_top_t  top_link,
  input wire logic      speaker_jack_detect,
  input wire logic      squelch_busy_n,
  input wire bum_band_t band_id,
  input wire logic      ident_done,
  input wire logic      speaker_present,
  input wire logic      channel_busy
);
  logic [7:0] hi_cnt;
  logic [7:0] next_hi_cnt;
  logic [7:0] le_cnt;
  logic [7:0] next_le_cnt;
  logic [7:0] ck_cnt;
  logic [7:0] next_ck_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Helpers: length of each PLL and shift register latch pulse and shared clock-high pulse, too long for a repetition
  always_comb begin
    next_hi_cnt = shift_register_enable ? hi_cnt + 8'h01 : 8'h00;
    next_le_cnt = link_out.pll_latch_enable ? le_cnt + 8'h01 : 8'h00;
    next_ck_cnt = link_out.serial_shift_clock ? ck_cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt <= 8'h00;
      le_cnt <= 8'h00;
      ck_cnt <= 8'h00;
    end else begin
      hi_cnt <= next_hi_cnt;
      le_cnt <= next_le_cnt;
      ck_cnt <= next_ck_cnt;
    end
  end

  // ==========================================================================
  // Line ownership, handshake, framing, status line follow and no-unit decode
  a_float_ident: assert property (!ident_done |-> link_oe == 3'b000)
    else $error("lines driven during identification");
  a_drive_after: assert property (ident_done |-> link_oe == 3'b111)
    else $error("lines not driven after identification");
  a_ready_drop: assert property (cmd_valid && cmd_ready && !mem_clear && cmd.kind <= BUM_SQUELCH |=> !cmd_ready)
    else $error("ready stayed high after a word was taken");
  a_pll_latch_len: assert property ($fell(link_out.pll_latch_enable) |-> le_cnt == 8'h0a)
    else $error("pll latch pulse not ten clocks");
  a_sreg_latch_len: assert property ($fell(shift_register_enable) |-> hi_cnt == 8'h0a)
    else $error("shift register latch pulse not ten clocks");
  a_latch_idle_shift: assert property (link_out.serial_shift_clock |-> !link_out.pll_latch_enable && !shift_register_enable)
    else $error("latch active while shifting");
  a_data_hold_fall: assert property ($fell(link_out.serial_shift_clock) |-> $stable(link_out.serial_shift_data) [*8])
    else $error("data moved around the falling clock edge");
  a_clock_high_len: assert property ($fell(link_out.serial_shift_clock) |-> ck_cnt == 8'h0a)
    else $error("shift clock high phase not ten clocks");
  a_speaker_follow: assert property (!$past(sys_rst) |-> speaker_present == $past(speaker_jack_detect))
    else $error("speaker present does not follow the jack line");
  a_busy_follow: assert property (!$past(sys_rst) |-> channel_busy == !$past(squelch_busy_n))
    else $error("channel busy does not follow the squelch line");
  a_no_unit_none: assert property ($rose(ident_done) && $past(link_in) == 3'b000 |-> band_id == BAND_NONE)
    else $error("all lines low not decoded as no unit");
endmodule

// *** tb/bum_band_unit_model.sv ***
// Band unit model: pulls its identification lines and latches the serial words it receives
`timescale 1ns/1ns
module bum_band_unit_model
  import bum_pkg::*;
(
  input  wire logic [2:0] band_code,
  input  wire bum_link_t  link_out,
  input  wire bum_link_t  link_oe,
  input  wire logic       shift_register_enable,
  input  wire bum_top_t   top_link,
  output bum_link_t       link_in,
  output logic            got,
  output logic [1:0]      got_sel,
  output logic [5:0]      got_len,
  output logic [31:0]     got_word
);
  logic [31:0] sh;
  logic [31:0] top_sh;
  logic [5:0]  n = 6'h0;
  logic [5:0]  top_n = 6'h0;
  wire         drv_ck = link_out.serial_shift_clock & link_oe.serial_shift_clock;
  wire         drv_le = link_out.pll_latch_enable & link_oe.pll_latch_enable;

  // ==========================================================================
  // Released lines: the fitted unit pulls its code high, the control side pulls the rest low
  assign link_in = bum_link_t'((link_out & link_oe) | (band_code & ~link_oe));

  initial got = 1'b0;

  // Hands on only this word's bits; that receiver's own bit counter restarts so stale bits never leak
  task automatic emit(input logic [1:0] sel);
    got_sel <= sel;
    got_len <= (sel == 2'd2) ? top_n : n;
    got_word <= (sel == 2'd2) ? top_sh & ~(32'hffffffff << top_n) : sh & ~(32'hffffffff << n);
    got <= ~got;
    if (sel == 2'd2) begin
      top_n <= 6'h0;
    end else begin
      n <= 6'h0;
    end
  endtask

  // ==========================================================================
  // Receivers take data on the falling clock edge; time zero settling is not a clock
  always @(negedge drv_ck) begin
    if ($time != 0) begin
      sh <= {sh[30:0], link_in.serial_shift_data};
      n <= n + 6'h1;
    end
  end
  always @(negedge top_link.top_shift_clock) begin
    if ($time != 0) begin
      top_sh <= {top_sh[30:0], top_link.top_shift_data};
      top_n <= top_n + 6'h1;
    end
  end
  // An aborted PLL or shift register word is dropped when the enable line is released
  always @(negedge link_oe.pll_latch_enable) n <= 6'h0;
  always @(posedge drv_le) emit(2'd0);
  always @(posedge shift_register_enable) emit(2'd1);
  always @(posedge top_link.top_band_latch_enable) emit(2'd2);
endmodule

// *** tb/test_band_unit_serial_control.sv ***
// Self-checking bench for the band unit serial control block
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin checks++; if ((sn) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn); end end
module test_band_unit_serial_control
  import bum_pkg::*;
;
  logic        clk, sys_rst, cmd_valid, mem_clear, top_ref_sel, cmd_ready, shift_register_enable;
  logic        speaker_jack_detect, squelch_busy_n, ident_done, speaker_present, channel_busy, got;
  bum_cmd_t    cmd;
  bum_link_t   link_in, link_out, link_oe;
  bum_top_t    top_link;
  bum_band_t   band_id;
  logic [1:0]  got_sel;
  logic [5:0]  got_len;
  logic [31:0] got_word;
  logic [39:0] head;
  logic [39:0] exp_q[$];
  logic [4:0]  lv[8];
  logic [2:0]  band_code = 3'b110;
  logic [2:0]  codes[8] = '{3'b000, 3'b001, 3'b011, 3'b111, 3'b110, 3'b101, 3'b100, 3'b010};
  bum_band_t   bands[8] = '{BAND_NONE, BAND_28, BAND_50, BAND_50, BAND_144, BAND_430, BAND_1200, BAND_UNKNOWN};
  logic        skip_top = 1'b0;
  integer      seed = 32'hff28;
  int          checks = 0, miscompares = 0, cycles = 0;

  bum_serial_ctrl u_bum_serial_ctrl (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .mem_clear(mem_clear), .top_ref_sel(top_ref_sel), .link_in(link_in), .link_out(link_out),
    .link_oe(link_oe), .shift_register_enable(shift_register_enable), .top_link(top_link),
    .speaker_jack_detect(speaker_jack_detect), .squelch_busy_n(squelch_busy_n), .band_id(band_id),
    .ident_done(ident_done), .speaker_present(speaker_present), .channel_busy(channel_busy));
  bum_band_unit_model u_bum_band_unit_model (
    .band_code(band_code), .link_out(link_out), .link_oe(link_oe), .shift_register_enable(shift_register_enable),
    .top_link(top_link), .link_in(link_in), .got(got), .got_sel(got_sel), .got_len(got_len), .got_word(got_word));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================================
  // Closing report, reached from the main sequence or the cycle ceiling
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for identification or for the command port
  task automatic wait_for(input logic ident);
    int k;
    k = 0;
    tick(1);
    while ((ident ? ident_done : cmd_ready) !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    `CHK("handshake", 1'b1, (ident ? ident_done : cmd_ready))
  endtask

  // Command held for exactly the one taking edge
  task automatic issue(input bum_kind_t k, input logic [2:0] a, input logic [16:0] v);
    wait_for(1'b0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= bum_cmd_t'({k, a, v});
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic pulse_clear;
    @(posedge clk);
    mem_clear <= 1'b1;
    @(posedge clk);
    mem_clear <= 1'b0;
  endtask

  // Random far-side status lines every cycle; also the hang ceiling
  always @(posedge clk) begin
    speaker_jack_detect <= 1'($random(seed));
    squelch_busy_n <= 1'($random(seed));
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  // Each latched word, bar top words while skip_top is set, is matched against the oldest note
  always @(got) begin
    if (cycles > 0 && !(skip_top && got_sel == 2'd2)) begin
      head = (exp_q.size() == 0) ? 40'h0 : exp_q.pop_front();
      `CHK("latched word", head, {got_sel, got_len, got_word})
    end
  end

  initial begin
    logic [16:0] v;
    int r;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    mem_clear = 1'b0;
    top_ref_sel = 1'b0;
    speaker_jack_detect = 1'b0;
    squelch_busy_n = 1'b1;
    exp_q.push_back({2'd2, 6'd16, 21'h0, 11'(1600000 / 1000)});
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_for(1'b1);
    `CHK("band_id", BAND_144, band_id)
    // Every retrieval code plus a stray one; the first clear aborts a word in flight
    // The power-on top reference word must be matched before top words are ignored
    wait_for(1'b0);
    skip_top = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 0) begin
        issue(BUM_PLL_N, 3'h1, 17'h1abcd);
        tick(5);
      end
      @(posedge clk);
      band_code <= codes[i];
      pulse_clear();
      wait_for(1'b1);
      `CHK("band_id", bands[i], band_id)
    end
    wait_for(1'b0);
    skip_top = 1'b0;
    // Fill all eight level slots, one write per issue call, then ship volume and squelch words
    for (int i = 0; i < 8; i++) begin
      lv[i] = 5'($random(seed));
      issue(BUM_LEVEL_WR, 3'(i), {12'h0, lv[i]});
    end
    v = 17'($random(seed));
    exp_q.push_back({2'd1, 6'd28, 4'h0, v[7:0], lv[0], lv[1], lv[2], lv[3]});
    issue(BUM_VOLUME, 3'h0, v);
    exp_q.push_back({2'd1, 6'd20, 12'h0, lv[4], lv[5], lv[6], lv[7]});
    issue(BUM_SQUELCH, 3'h0, v);
    // Division words, each followed by one of the two reference choices
    for (int i = 0; i < 2; i++) begin
      v = 17'($random(seed));
      exp_q.push_back({2'd0, 6'd21, 11'h0, v, 1'b0, 3'(i + 5)});
      issue(BUM_PLL_N, 3'(i + 5), v);
      r = (i == 0) ? 320 : 256;
      exp_q.push_back({2'd0, 6'd21, 11'h0, 17'(12800 + 8 * r), 4'h0});
      issue(BUM_PLL_REF, 3'h0, 17'(i));
    end
    v = 17'($random(seed));
    exp_q.push_back({2'd2, 6'd16, 16'h0, v[15:0]});
    issue(BUM_TOP_N, 3'h0, v);
    issue(bum_kind_t'(3'h6), 3'h0, v);
    // A reference switch queues exactly one new top reference word
    wait_for(1'b0);
    exp_q.push_back({2'd2, 6'd16, 21'h0, 11'(1600000 / 1250)});
    @(posedge clk);
    top_ref_sel <= 1'b1;
    for (int k = 0; k < 3000 && exp_q.size() != 0; k++) tick(1);
    tick(100);
    `CHK("pending words", 0, exp_q.size())
    finish_test();
  end
endmodule

bind bum_serial_ctrl bum_serial_ctrl_props u_bum_serial_ctrl_props (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .mem_clear(mem_clear), .top_ref_sel(top_ref_sel), .link_in(link_in), .link_out(link_out),
  .link_oe(link_oe), .shift_register_enable(shift_register_enable), .top_link(top_link),
  .speaker_jack_detect(speaker_jack_detect), .squelch_busy_n(squelch_busy_n), .band_id(band_id),
  .ident_done(ident_done), .speaker_present(speaker_present), .channel_busy(channel_busy));
